// *** boot_strap_pkg.sv ***
// Purpose: shared constants and types for the boot strap pin configuration block
// Assumes: 32-bit register port, byte offsets on word boundaries
// Notes: strap bit positions index the captured address and data pin values
package boot_strap_pkg;
	// register byte offsets
	localparam logic [7:0] CHIP_CONFIG_OFS = 8'h00;
	localparam logic [7:0] PIN_CONFIG_OFS = 8'h04;
	localparam logic [7:0] EXT_BUS_CTRL_OFS = 8'h08;
	localparam logic [7:0] STRAP_ADDR_OFS = 8'h0c;
	localparam logic [7:0] STRAP_DATA_OFS = 8'h10;
	// chip_config_reg fields
	localparam int SD_EN_LSB = 0;
	localparam int IO_EN_BIT = 4;
	// pin_config_reg fields
	localparam int FB_INT_BIT = 0;
	localparam int PCI_EN_LSB = 8;
	// ext_bus_channel_ctrl fields
	localparam int BE_STYLE_BIT = 0;
	// strap_data status flag
	localparam int BOOT_DONE_BIT = 16;
	// reset values
	localparam logic [3:0] SD_EN_RST = 4'hf;
	localparam logic IO_EN_RST = 1'h1;
	localparam logic FB_INT_RST = 1'h0;
	localparam logic [5:0] PCI_EN_RST = 6'h3f;
	// strap positions on the address pins
	localparam int STRAP_ROLE_BIT = 19;
	localparam int STRAP_ECC_BIT = 18;
	localparam int STRAP_IODIV_MSB = 14;
	localparam int STRAP_IODIV_LSB = 13;
	localparam int STRAP_AUDIO_BIT = 9;
	// strap positions on the data pins
	localparam int STRAP_STYLE_BIT = 5;
	localparam int STRAP_ARB_BIT = 2;
	// sdram address drives only the upper bits
	localparam int SD_ADDR_LSB = 5;
	// external bus width codes
	typedef enum logic [1:0] {
		BW_32 = 2'b00,
		BW_16 = 2'b01,
		BW_8 = 2'b10,
		BW_RSVD = 2'b11
	} bus_width_e;
	// boot sequence after reset release
	typedef enum logic [1:0] {
		BOOT_FILL = 2'b00,
		BOOT_SETTLE = 2'b01,
		BOOT_CAPTURE = 2'b10,
		BOOT_RUN = 2'b11
	} boot_state_e;
	// every pin input, sampled together
	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] data;
		logic [7:0] check;
		logic dma_a;
		logic done_n;
		logic [3:0] req_n;
		logic [3:0] gnt_n;
		logic sys_error_n;
		logic fb_clk;
	} pins_in_s;
endpackage

// *** boot_strap_pin_config.sv ***
// Purpose: boot strap capture and pin function and direction control
// Assumes: ref_clk is twice the system bus clock; clock outputs toggle on ref_clk
// Notes: all pin inputs pass a two-flop synchroniser before use
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - address pins stay inputs in reset, become driven outputs after straps are taken.
// - address and low sixteen data pins are sampled as boot configuration.
// - sdram accesses drive address only on bits 19 down to 5.
// - bus separate output high isolates non-sdram devices, low connects them.
// - four sdram clocks run at bus clock; cleared enable bit holds one high.
// - feedback enable set feeds sdram clock internally and drives feedback pin.
// - eight data mask outputs, one per byte lane, bit 0 lowest byte.
// - eight check bit lines, one per byte lane, bit 0 lowest byte.
// - address bit 18 strap picks upper parallel io or check bits.
// - two-bit strap divides external io clock by one to four.
// - cleared external clock enable holds external io clock high.
// - byte-enable style marks lanes on reads and writes, byte-write only writes.
// - sixteen-bit bus uses lower two strobes, eight-bit bus lowest only.
// - strobe style comes from data bit 5 strap and channel control register.
// - address bit 9 strap picks dma channel 2 or audio link pins.
// - dma done pin reports finish as output and forces termination as input.
// - six pci clocks, each held high when its enable bit is cleared.
// - internal arbiter makes four request pins inputs, four grant pins outputs.
// - external arbiter drives request 0, takes grant 0, grants 1-3 inputs.
// - external arbiter turns request 1 into open-drain interrupt output.
// - address bit 19 strap picks host input or satellite open-drain system error.
module boot_strap_pin_config
	import boot_strap_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// pin inputs
	input wire pins_in_s pins_in,
	// address pins and bus separation
	output logic [19:0] addr_out,
	output logic [19:0] addr_oe,
	output logic bus_separate_n,
	// sdram side pins
	output logic [3:0] sdram_clk_out,
	output logic sdram_feedback_clk_out,
	output logic sdram_feedback_clk_oe,
	output logic [7:0] data_mask,
	output logic [7:0] check_bits_out,
	output logic [7:0] check_bits_oe,
	// external bus pins
	output logic external_io_clk,
	output logic [3:0] lane_strobe_n,
	// dma and audio pins
	output logic dma_pin_a_out,
	output logic dma_pin_a_oe,
	output logic dma_pin_b_out,
	output logic dma_finished_n_out,
	output logic dma_finished_n_oe,
	// pci pins
	output logic [5:0] pci_clk_out,
	output logic [3:0] pci_req_n_out,
	output logic [3:0] pci_req_n_oe,
	output logic [3:0] pci_gnt_n_out,
	output logic [3:0] pci_gnt_n_oe,
	output logic sys_error_n_out,
	output logic sys_error_n_oe,
	// sdram controller side
	input wire logic sdram_active,
	input wire logic [19:5] sdram_addr_hi,
	input wire logic [7:0] data_mask_req,
	input wire logic [7:0] ecc_out,
	input wire logic [7:0] ecc_oe,
	output logic [7:0] ecc_in,
	output logic sdram_feedback_clk,
	// parallel io side
	input wire logic [7:0] parallel_io_upper_out,
	input wire logic [7:0] parallel_io_upper_oe,
	output logic [7:0] parallel_io_upper_in,
	// external bus controller side
	input wire logic ebus_active,
	input wire logic ebus_write,
	input wire logic [1:0] ebus_width,
	input wire logic [19:0] ebus_addr,
	input wire logic [3:0] ebus_lanes_n,
	// dma and audio side
	input wire logic dma_acknowledge_ch2,
	input wire logic audio_link_reset_n,
	input wire logic audio_sync,
	input wire logic dma_done_report,
	output logic dma_request_ch2,
	output logic dma_terminate,
	// pci side
	input wire logic own_req_n,
	input wire logic external_irq_out,
	input wire logic [3:0] arb_gnt_n,
	input wire logic sys_error_req,
	output logic [3:0] arb_req_n,
	output logic own_gnt_n,
	output logic sys_error_seen,
	// captured mode flags
	output logic boot_done,
	output logic host_role,
	output logic internal_arbiter
);

	typedef struct packed {
		boot_state_e boot;
		logic booted;
		pins_in_s s1;
		pins_in_s s2;
		logic [19:0] strap_addr;
		logic [15:0] strap_data;
		logic [3:0] sd_en;
		logic io_en;
		logic fb_int;
		logic [5:0] pci_en;
		logic be_style;
		logic [31:0] rdata;
		logic phase;
		logic [1:0] io_cnt;
		logic io_tog;
		logic [19:0] addr_o;
		logic [19:0] addr_oe;
		logic bus_sep_n;
		logic [3:0] sd_clk;
		logic fb_o;
		logic fb_oe;
		logic fb_ctrl;
		logic [7:0] mask;
		logic [7:0] cb_o;
		logic [7:0] cb_oe;
		logic [7:0] ecc_i;
		logic [7:0] pio_i;
		logic io_clk;
		logic [3:0] lane_n;
		logic dma_a_o;
		logic dma_a_oe;
		logic dma_b_o;
		logic dma_req2;
		logic done_o;
		logic done_oe;
		logic dma_term;
		logic [1:0] done_oe_d;
		logic [5:0] pci_clk;
		logic [3:0] req_o;
		logic [3:0] req_oe;
		logic [3:0] gnt_o;
		logic [3:0] gnt_oe;
		logic [3:0] arb_req;
		logic own_gnt;
		logic serr_o;
		logic serr_oe;
		logic serr_seen;
	} state_s;

	localparam state_s ST_RESET = '{
		boot: BOOT_FILL,
		sd_en: SD_EN_RST,
		io_en: IO_EN_RST,
		fb_int: FB_INT_RST,
		pci_en: PCI_EN_RST,
		bus_sep_n: 1'h1,
		sd_clk: 4'hf,
		fb_o: 1'h1,
		io_clk: 1'h1,
		lane_n: 4'hf,
		dma_a_o: 1'h1,
		dma_b_o: 1'h0,
		done_o: 1'h1,
		pci_clk: 6'h3f,
		req_o: 4'hf,
		gnt_o: 4'hf,
		arb_req: 4'hf,
		own_gnt: 1'h1,
		serr_o: 1'h1,
		default: '0
	};

	state_s st;
	state_s next_st;
	logic run;
	logic ecc_mode;
	logic audio_mode;
	logic arb_int;
	logic host;
	logic [1:0] io_div;
	logic [3:0] width_mask;

	// next state of every register in the block
	always_comb begin
		next_st = st;
		next_st.s1 = pins_in;
		next_st.s2 = st.s1;
		next_st.rdata = 32'h0;

		// straps settle through the synchroniser, then are frozen
		unique case (st.boot)
			BOOT_FILL: next_st.boot = BOOT_SETTLE;
			BOOT_SETTLE: next_st.boot = BOOT_CAPTURE;
			BOOT_CAPTURE: next_st.boot = BOOT_RUN;
			BOOT_RUN: next_st.boot = BOOT_RUN;
		endcase
		next_st.booted = (next_st.boot == BOOT_RUN);
		// register writes
		if (reg_wr) begin
			unique case (reg_addr)
				CHIP_CONFIG_OFS: begin
					next_st.sd_en = reg_wdata[SD_EN_LSB +: 4];
					next_st.io_en = reg_wdata[IO_EN_BIT];
				end
				PIN_CONFIG_OFS: begin
					next_st.fb_int = reg_wdata[FB_INT_BIT];
					next_st.pci_en = reg_wdata[PCI_EN_LSB +: 6];
				end
				EXT_BUS_CTRL_OFS: next_st.be_style = reg_wdata[BE_STYLE_BIT];
				default: ;
			endcase
		end
		// capture wins over a write to the style bit in the same cycle
		if (st.boot == BOOT_CAPTURE) begin
			next_st.strap_addr = st.s2.addr;
			next_st.strap_data = st.s2.data;
			next_st.be_style = st.s2.data[STRAP_STYLE_BIT];
		end
		// register reads, answered in the next cycle
		if (reg_rd) begin
			unique case (reg_addr)
				CHIP_CONFIG_OFS: begin
					next_st.rdata[SD_EN_LSB +: 4] = st.sd_en;
					next_st.rdata[IO_EN_BIT] = st.io_en;
				end
				PIN_CONFIG_OFS: begin
					next_st.rdata[FB_INT_BIT] = st.fb_int;
					next_st.rdata[PCI_EN_LSB +: 6] = st.pci_en;
				end
				EXT_BUS_CTRL_OFS: next_st.rdata[BE_STYLE_BIT] = st.be_style;
				STRAP_ADDR_OFS: next_st.rdata[19:0] = st.strap_addr;
				STRAP_DATA_OFS: begin
					next_st.rdata[15:0] = st.strap_data;
					next_st.rdata[BOOT_DONE_BIT] = run;
				end
				default: ;
			endcase
		end
		// sdram and pci clocks: one ref_clk cycle per half period
		next_st.phase = ~st.phase;
		for (int i = 0; i < 4; i++) begin
			next_st.sd_clk[i] = st.sd_en[i] ? next_st.phase : 1'b1;
		end
		for (int i = 0; i < 6; i++) begin
			next_st.pci_clk[i] = st.pci_en[i] ? next_st.phase : 1'b1;
		end

		// external io clock: half period of one to four ref_clk cycles
		if (st.io_cnt == io_div) begin
			next_st.io_cnt = 2'h0;
			next_st.io_tog = ~st.io_tog;
		end else begin
			next_st.io_cnt = st.io_cnt + 2'h1;
		end
		next_st.io_clk = st.io_en ? next_st.io_tog : 1'b1;

		// feedback clock, internal or from the pin
		next_st.fb_o = st.phase;
		next_st.fb_oe = run & st.fb_int;
		next_st.fb_ctrl = st.fb_int ? st.phase : st.s2.fb_clk;

		// address pins and bus separation
		next_st.addr_oe = run ? 20'hfffff : 20'h0;
		if (sdram_active) begin
			next_st.addr_o = {sdram_addr_hi, 5'h0};
		end else begin
			next_st.addr_o = ebus_addr;
		end
		next_st.bus_sep_n = ~ebus_active;

		// byte lane masks and check bits share the lane order
		next_st.mask = data_mask_req;
		if (ecc_mode) begin
			next_st.cb_o = ecc_out;
			next_st.cb_oe = run ? ecc_oe : 8'h0;
			next_st.ecc_i = st.s2.check;
			next_st.pio_i = 8'h0;
		end else begin
			next_st.cb_o = parallel_io_upper_out;
			next_st.cb_oe = run ? parallel_io_upper_oe : 8'h0;
			next_st.ecc_i = 8'h0;
			next_st.pio_i = st.s2.check;
		end

		// lane strobes by style and bus width
		if (!ebus_active) begin
			next_st.lane_n = 4'hf;
		end else if (st.be_style || ebus_write) begin
			next_st.lane_n = ebus_lanes_n | width_mask;
		end else begin
			next_st.lane_n = 4'hf;
		end

		// dma channel 2 or audio link on the shared pins
		if (audio_mode) begin
			next_st.dma_a_o = audio_link_reset_n;
			next_st.dma_a_oe = run;
			next_st.dma_b_o = audio_sync;
			next_st.dma_req2 = 1'b0;
		end else begin
			next_st.dma_a_o = 1'b1;
			next_st.dma_a_oe = 1'b0;
			next_st.dma_b_o = dma_acknowledge_ch2;
			next_st.dma_req2 = run & st.s2.dma_a;
		end

		// done pin: pulled low to report, sensed low to terminate
		next_st.done_o = 1'b0;
		next_st.done_oe = run & dma_done_report;
		next_st.done_oe_d = {st.done_oe_d[0], st.done_oe}; // own drive, delayed as far as the synchroniser
		next_st.dma_term = run & ~st.s2.done_n & ~st.done_oe_d[1];

		// pci request and grant directions
		if (arb_int) begin
			next_st.req_o = 4'hf;
			next_st.req_oe = 4'h0;
			next_st.arb_req = st.s2.req_n;
			next_st.gnt_o = arb_gnt_n;
			next_st.gnt_oe = run ? 4'hf : 4'h0;
			next_st.own_gnt = 1'b1;
		end else begin
			next_st.req_o = {3'b110, own_req_n};
			next_st.req_oe = {2'b00, run & external_irq_out, run};
			next_st.arb_req = 4'hf;
			next_st.gnt_o = 4'hf;
			next_st.gnt_oe = 4'h0;
			next_st.own_gnt = st.s2.gnt_n[0];
		end

		// system error by role
		next_st.serr_o = 1'b0;
		if (host) begin
			next_st.serr_oe = 1'b0;
			next_st.serr_seen = run & ~st.s2.sys_error_n;
		end else begin
			next_st.serr_oe = run & sys_error_req;
			next_st.serr_seen = 1'b0;
		end
	end

	// decoded straps, valid once held
	assign run = st.booted;
	assign ecc_mode = st.strap_addr[STRAP_ECC_BIT];
	assign audio_mode = st.strap_addr[STRAP_AUDIO_BIT];
	assign arb_int = st.strap_data[STRAP_ARB_BIT];
	assign host = st.strap_addr[STRAP_ROLE_BIT];
	assign io_div = st.strap_addr[STRAP_IODIV_MSB:STRAP_IODIV_LSB];

	// unused upper lanes stay inactive
	always_comb begin
		unique case (bus_width_e'(ebus_width))
			BW_32: width_mask = 4'h0;
			BW_16: width_mask = 4'hc;
			BW_8: width_mask = 4'he;
			BW_RSVD: width_mask = 4'h0;
		endcase
	end

	// the single state register; straps held until next reset
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register, grouped as the ports are
	assign reg_rdata = st.rdata;
	assign {addr_out, addr_oe, bus_separate_n} = {st.addr_o, st.addr_oe, st.bus_sep_n};
	assign {sdram_clk_out, sdram_feedback_clk_out, sdram_feedback_clk_oe} = {st.sd_clk, st.fb_o, st.fb_oe};
	assign {data_mask, check_bits_out, check_bits_oe} = {st.mask, st.cb_o, st.cb_oe};
	assign {external_io_clk, lane_strobe_n} = {st.io_clk, st.lane_n};
	assign {dma_pin_a_out, dma_pin_a_oe, dma_pin_b_out} = {st.dma_a_o, st.dma_a_oe, st.dma_b_o};
	assign {dma_finished_n_out, dma_finished_n_oe} = {st.done_o, st.done_oe};
	assign {pci_clk_out, pci_req_n_out, pci_req_n_oe} = {st.pci_clk, st.req_o, st.req_oe};
	assign {pci_gnt_n_out, pci_gnt_n_oe} = {st.gnt_o, st.gnt_oe};
	assign {sys_error_n_out, sys_error_n_oe} = {st.serr_o, st.serr_oe};
	assign {ecc_in, sdram_feedback_clk, parallel_io_upper_in} = {st.ecc_i, st.fb_ctrl, st.pio_i};
	assign {dma_request_ch2, dma_terminate} = {st.dma_req2, st.dma_term};
	assign {arb_req_n, own_gnt_n, sys_error_seen} = {st.arb_req, st.own_gnt, st.serr_seen};
	assign {boot_done, host_role, internal_arbiter} = {st.booted, host, arb_int};

endmodule // boot_strap_pin_config

`default_nettype wire

// *** boot_strap_sva.sv ***
// Purpose: port-level checks of the boot strap pin block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module boot_strap_sva
	import boot_strap_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// mode flags and pins
	input wire logic boot_done,
	input wire logic host_role,
	input wire logic internal_arbiter,
	input wire logic [19:0] addr_out,
	input wire logic [19:0] addr_oe,
	input wire logic bus_separate_n,
	input wire logic [3:0] lane_strobe_n,
	input wire logic [7:0] data_mask,
	input wire logic [3:0] pci_req_n_oe,
	input wire logic [3:0] pci_gnt_n_oe,
	input wire logic sys_error_n_oe,
	// user side
	input wire logic sdram_active,
	input wire logic [19:5] sdram_addr_hi,
	input wire logic ebus_active,
	input wire logic [1:0] ebus_width,
	input wire logic [7:0] data_mask_req,
	input wire logic external_irq_out
);
	// one clock, one reset for every check
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	addr_in_boot_a:
		assert property (!boot_done |-> addr_oe == 20'h0) else $error("address pins driven before boot");
	sdram_addr_a:
		assert property ($past(boot_done) && $past(sdram_active) |-> addr_out == {$past(sdram_addr_hi), 5'h0})
		else $error("sdram address wrong");
	bus_separate_a:
		assert property (boot_done |-> bus_separate_n == !$past(ebus_active)) else $error("bus separate wrong");
	mask_lane_a:
		assert property (boot_done |-> data_mask == $past(data_mask_req)) else $error("data mask wrong");
	narrow_lanes_a:
		assert property ($past(boot_done) && $past(ebus_active) && $past(ebus_width) == BW_8
			|-> lane_strobe_n[3:1] == 3'h7) else $error("upper strobes used on narrow bus");
	arb_dir_a:
		assert property ($past(boot_done, 2) |-> (pci_gnt_n_oe == (internal_arbiter ? 4'hf : 4'h0))
			&& (pci_req_n_oe[3:2] == 2'h0)) else $error("arbiter pin directions wrong");
	irq_out_a:
		assert property ($past(boot_done, 2) && !internal_arbiter |-> pci_req_n_oe[1] == $past(external_irq_out))
		else $error("interrupt output wrong");
	straps_held_a:
		assert property (boot_done && $past(boot_done) |-> $stable(host_role) && $stable(internal_arbiter))
		else $error("captured modes changed");
	serr_host_a:
		assert property ($past(boot_done, 2) && host_role |-> !sys_error_n_oe) else $error("system error driven in host role");
endmodule // boot_strap_sva

bind boot_strap_pin_config boot_strap_sva i_boot_strap_sva (.ref_clk, .arst_n, .boot_done, .host_role,
	.internal_arbiter, .addr_out, .addr_oe, .bus_separate_n, .lane_strobe_n, .data_mask, .pci_req_n_oe,
	.pci_gnt_n_oe, .sys_error_n_oe, .sdram_active, .sdram_addr_hi, .ebus_active, .ebus_width, .data_mask_req,
	.external_irq_out);
`default_nettype wire

// *** far_side_pins.sv ***
// Purpose: board side of the pins: straps, pull-ups and open-drain resolution
// Assumes: straps stand on the pins until boot is done
// Notes: undriven pins with pull-ups read high
`timescale 1ns/1ns
`default_nettype none
module far_side_pins
	import boot_strap_pkg::*;
(
	// strap values and board inputs
	input wire logic [19:0] strap_addr,
	input wire logic [15:0] strap_data,
	input wire logic done_n_ext,
	input wire logic boot_done,
	// drives from the block
	input wire logic [19:0] addr_out,
	input wire logic [19:0] addr_oe,
	input wire logic [7:0] check_bits_out,
	input wire logic [7:0] check_bits_oe,
	input wire logic dma_pin_a_out,
	input wire logic dma_pin_a_oe,
	input wire logic dma_finished_n_oe,
	input wire logic [3:0] pci_req_n_out,
	input wire logic [3:0] pci_req_n_oe,
	input wire logic [3:0] pci_gnt_n_out,
	input wire logic [3:0] pci_gnt_n_oe,
	input wire logic sys_error_n_oe,
	input wire logic sdram_feedback_clk_out,
	input wire logic sdram_feedback_clk_oe,
	// resolved levels
	output var pins_in_s pins_in
);
	// each pin is the driver where enabled, else its pull level
	always_comb begin
		pins_in.addr = boot_done ? (addr_out & addr_oe | ~addr_oe) : strap_addr;
		pins_in.data = boot_done ? 16'hffff : strap_data;
		pins_in.check = check_bits_out & check_bits_oe | ~check_bits_oe;
		pins_in.dma_a = dma_pin_a_oe ? dma_pin_a_out : 1'b1;
		pins_in.done_n = dma_finished_n_oe ? 1'b0 : done_n_ext;
		pins_in.req_n = pci_req_n_out & pci_req_n_oe | ~pci_req_n_oe;
		pins_in.gnt_n = pci_gnt_n_out & pci_gnt_n_oe | ~pci_gnt_n_oe;
		pins_in.sys_error_n = !sys_error_n_oe;
		pins_in.fb_clk = sdram_feedback_clk_oe ? sdram_feedback_clk_out : 1'b0;
	end
endmodule // far_side_pins
`default_nettype wire

// *** testbench.sv ***
// Purpose: self-checking bench for the boot strap pin block
// Assumes: 125 MHz ref_clk, straps from far_side_pins
// Notes: each strap combination gets its own reset
`timescale 1ns/1ns
`default_nettype none
module testbench
	import boot_strap_pkg::*;
;
	logic ref_clk, arst_n, reg_wr, reg_rd, sdram_active, ebus_active, ebus_write, dma_acknowledge_ch2, h;
	logic audio_link_reset_n, audio_sync, dma_done_report, external_irq_out, done_n_ext, boot_done, host_role;
	logic internal_arbiter, bus_separate_n, external_io_clk, dma_terminate, dma_pin_a_out, dma_pin_a_oe;
	logic dma_pin_b_out, dma_finished_n_oe, sys_error_n_oe, sdram_feedback_clk_out, sdram_feedback_clk_oe;
	logic [1:0] ebus_width;
	logic [3:0] ebus_lanes_n, lane_strobe_n, sdram_clk_out, pci_req_n_out, pci_req_n_oe, pci_gnt_n_out, pci_gnt_n_oe;
	logic [5:0] pci_clk_out;
	logic [7:0] reg_addr, data_mask_req, data_mask, ecc_out, ecc_oe, parallel_io_upper_out, parallel_io_upper_oe;
	logic [7:0] check_bits_out, check_bits_oe, ecc_in, parallel_io_upper_in;
	logic own_req_n, sys_error_req;
	logic [15:0] strap_data;
	logic [19:5] sdram_addr_hi;
	logic [19:0] strap_addr, addr_out, addr_oe;
	logic [31:0] reg_wdata, reg_rdata;
	pins_in_s pins_in;
	int fails, n_compared;

	boot_strap_pin_config i_boot_strap_pin_config (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .pins_in, .addr_out, .addr_oe, .bus_separate_n, .sdram_clk_out, .sdram_feedback_clk_out,
		.sdram_feedback_clk_oe, .data_mask, .check_bits_out, .check_bits_oe, .external_io_clk, .lane_strobe_n,
		.dma_pin_a_out, .dma_pin_a_oe, .dma_pin_b_out, .dma_finished_n_out(), .dma_finished_n_oe, .pci_clk_out,
		.pci_req_n_out, .pci_req_n_oe, .pci_gnt_n_out, .pci_gnt_n_oe, .sys_error_n_out(), .sys_error_n_oe,
		.sdram_active, .sdram_addr_hi, .data_mask_req, .ecc_out, .ecc_oe, .ecc_in, .sdram_feedback_clk(),
		.parallel_io_upper_out, .parallel_io_upper_oe, .parallel_io_upper_in, .ebus_active, .ebus_write,
		.ebus_width, .ebus_addr(20'h0), .ebus_lanes_n, .dma_acknowledge_ch2, .audio_link_reset_n, .audio_sync,
		.dma_done_report, .dma_request_ch2(), .dma_terminate, .own_req_n, .external_irq_out,
		.arb_gnt_n(4'hf), .sys_error_req, .arb_req_n(), .own_gnt_n(), .sys_error_seen(), .boot_done,
		.host_role, .internal_arbiter);
	far_side_pins i_far_side_pins (.strap_addr, .strap_data, .done_n_ext, .boot_done, .addr_out, .addr_oe,
		.check_bits_out, .check_bits_oe, .dma_pin_a_out, .dma_pin_a_oe, .dma_finished_n_oe, .pci_req_n_out,
		.pci_req_n_oe, .pci_gnt_n_out, .pci_gnt_n_oe, .sys_error_n_oe, .sdram_feedback_clk_out,
		.sdram_feedback_clk_oe, .pins_in);

	// 8 ns clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// wait n edges, then let their updates settle
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		step(1);
		reg_wr <= 1'b0;
		step(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		step(1);
		reg_rd <= 1'b0;
		chk(reg_rdata, exp);
		step(1);
	endtask
	// straps: role, ecc and audio follow i[0]/i[1]; divider is i
	task automatic boot(input logic [1:0] i);
		int n;
		arst_n <= 1'b0;
		strap_addr <= {i[0], i[1], 3'h0, i, 3'h5, i[0], 9'h0a6};
		strap_data <= {10'h2c3, i[1], 2'h1, i[0], 2'h2};
		step(8);
		arst_n <= 1'b1;
		n = 0;
		while (boot_done !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		chk(n < 20, 1'b1);
		step(2);
	endtask
	task automatic t_regs();
		rd(CHIP_CONFIG_OFS, {27'h0, IO_EN_RST, SD_EN_RST});
		rd(PIN_CONFIG_OFS, {18'h0, PCI_EN_RST, 7'h0, FB_INT_RST});
		wr(STRAP_ADDR_OFS, 32'h0);
		rd(STRAP_ADDR_OFS, {12'h0, strap_addr});
		rd(STRAP_DATA_OFS, {15'h0, 1'b1, strap_data});
		rd(EXT_BUS_CTRL_OFS, {31'h0, strap_data[STRAP_STYLE_BIT]});
		rd(8'h14, 32'h0);
	endtask
	task automatic t_modes(input logic [1:0] i);
		int n;
		chk(host_role, i[0]);
		chk(internal_arbiter, i[0]);
		ecc_out <= 8'ha5;
		parallel_io_upper_out <= 8'h3c;
		ebus_active <= 1'b1;
		ebus_write <= 1'b0;
		ebus_width <= BW_32;
		step(1);
		chk(lane_strobe_n, i[1] ? 4'h0 : 4'hf);
		chk(check_bits_out, i[1] ? 8'ha5 : 8'h3c);
		chk(dma_pin_a_oe, i[0]);
		chk(dma_pin_b_out, !i[0]);
		ebus_write <= 1'b1;
		ebus_width <= i[0] ? BW_16 : BW_8;
		step(1);
		chk(lane_strobe_n, i[0] ? 4'hc : 4'he);
		ebus_active <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			h = external_io_clk;
			while (external_io_clk === h && n < 9) begin
				step(1);
				n++;
			end
		end
		chk(n, i + 1);
	endtask
	task automatic t_pins(input logic [1:0] i);
		sdram_active <= 1'b1;
		sdram_addr_hi <= 15'h5a3c;
		data_mask_req <= 8'h81;
		external_irq_out <= 1'b1;
		done_n_ext <= 1'b0;
		own_req_n <= 1'b0;
		sys_error_req <= 1'b1;
		step(3);
		chk(dma_terminate, 1'b1);
		chk(addr_oe, 20'hfffff);
		chk(addr_out, {15'h5a3c, 5'h0});
		chk(data_mask, 8'h81);
		chk(bus_separate_n, 1'b1);
		chk(pci_req_n_oe[1], !i[0]);
		chk(pci_req_n_out[0], i[0]);
		chk(sys_error_n_oe, !i[0]);
		chk(ecc_in, i[1] ? 8'ha5 : 8'h0);
		chk(parallel_io_upper_in, i[1] ? 8'h0 : 8'h3c);
		done_n_ext <= 1'b1;
		dma_done_report <= 1'b1;
		sdram_active <= 1'b0;
		ebus_active <= 1'b1;
		step(1);
		chk(dma_finished_n_oe, 1'b1);
		chk(bus_separate_n, 1'b0);
		ebus_active <= 1'b0;
		dma_done_report <= 1'b0;
		external_irq_out <= 1'b0;
		own_req_n <= 1'b1;
		sys_error_req <= 1'b0;
		step(3);
		chk(dma_terminate, 1'b0);
	endtask
	task automatic t_clocks();
		wr(CHIP_CONFIG_OFS, 32'h5);
		wr(PIN_CONFIG_OFS, 32'h1501);
		repeat (3) begin
			step(1);
			chk(sdram_clk_out[3] & sdram_clk_out[1], 1'b1);
			chk(external_io_clk, 1'b1);
			chk(pci_clk_out[5] & pci_clk_out[3] & pci_clk_out[1], 1'b1);
		end
		h = sdram_clk_out[0];
		step(1);
		chk(sdram_clk_out[0], !h);
		chk(sdram_feedback_clk_oe, 1'b1);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// cut a hang short
	initial begin
		#100000;
		fails++;
		end_of_test();
	end
	// main sequence
	initial begin
		{arst_n, reg_wr, reg_rd, sdram_active, ebus_active, ebus_write, audio_link_reset_n, audio_sync} = 8'h0;
		{own_req_n, sys_error_req, dma_done_report, external_irq_out, done_n_ext, dma_acknowledge_ch2} = 6'h23;
		{reg_addr, reg_wdata, sdram_addr_hi, data_mask_req, ecc_out, parallel_io_upper_out} = '0;
		{ecc_oe, parallel_io_upper_oe, ebus_width, ebus_lanes_n} = {16'hffff, BW_32, 4'h0};
		{strap_addr, strap_data, fails, n_compared} = '0;
		for (int i = 0; i < 4; i++) begin
			boot(i[1:0]);
			t_regs();
			t_modes(i[1:0]);
			t_pins(i[1:0]);
		end
		t_clocks();
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
